// ---- rtl/shared_port_pkg.sv ----
package shared_port_pkg;

  // port widths
  localparam int TMR_W = 8;
  localparam int SER_W = 3;
  localparam int FRT_W = 8;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // register addresses
  localparam logic [ADDR_W-1:0] A_TMR_DDR = 16'hFFB5;
  localparam logic [ADDR_W-1:0] A_TMR_DR  = 16'hFFB7;
  localparam logic [ADDR_W-1:0] A_SER_DDR = 16'hFFB8;
  localparam logic [ADDR_W-1:0] A_FRT_DDR = 16'hFFB9;
  localparam logic [ADDR_W-1:0] A_SER_DR  = 16'hFFBA;
  localparam logic [ADDR_W-1:0] A_FRT_DR  = 16'hFFBB;

  // reset values, writable masks and read values
  localparam logic [DATA_W-1:0] RST_TMR   = 8'h00;
  localparam logic [DATA_W-1:0] RST_SER   = 8'hF8;
  localparam logic [DATA_W-1:0] RST_FRT   = 8'h00;
  localparam logic [DATA_W-1:0] MASK_ALL  = 8'hFF;
  localparam logic [DATA_W-1:0] MASK_SER  = 8'h07;
  localparam logic [DATA_W-1:0] RD_WO     = 8'hFF;
  localparam logic [DATA_W-1:0] RD_NONE   = 8'h00;

  // timer-shared port pin positions
  localparam int TMR_CLK0_BIT = 0;
  localparam int TMR_OUT0_BIT = 1;
  localparam int TMR_RST0_BIT = 2;
  localparam int TMR_CLK1_BIT = 3;
  localparam int TMR_OUT1_BIT = 4;
  localparam int TMR_RST1_BIT = 5;
  localparam int PWM0_BIT     = 6;
  localparam int PWM1_BIT     = 7;

  // serial-shared port pin positions
  localparam int SER_TX_BIT  = 0;
  localparam int SER_RX_BIT  = 1;
  localparam int SER_CLK_BIT = 2;

  // free-running-timer port pin positions
  localparam int FRT_CLK_BIT  = 0;
  localparam int FRT_CMA_BIT  = 1;
  localparam int FRT_CAP0_BIT = 2;
  localparam int FRT_CAP_N    = 4;
  localparam int FRT_CMB_BIT  = 6;
  localparam int FRT_EXT_INTERRUPT_SIX_BIT = 6;
  localparam int FRT_EXT_INTERRUPT_SEVEN_BIT = 7;

endpackage

// ---- rtl/port_latch_reg.sv ----
`timescale 1ns/1ps
module port_latch_reg #(
  parameter int                               W     = 8,
  parameter logic [W-1:0]                     RST   = '0,
  parameter logic [W-1:0]                     WMASK = '1
) (
  input  wire logic                           clk,
  input  wire logic                           arst_n,
  input  wire logic                           hw_clear,
  input  wire logic                           wr_en,
  input  wire logic [W-1:0]                   wdata,
  output logic      [W-1:0]                   q
);
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_q;

  // fixed bits always take their reset level
  assign nxt_q = hw_clear ? RST :
                 wr_en    ? ((wdata & WMASK) | (RST & ~WMASK)) : q_ff;
  assign q     = q_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q_ff <= RST;
    end else begin
      q_ff <= nxt_q;
    end
  end
endmodule // port_latch_reg

// ---- rtl/port_pin_mux.sv ----
`timescale 1ns/1ps
module port_pin_mux (
  input  wire logic ddr,
  input  wire logic dr,
  input  wire logic pin_in,
  input  wire logic per_use,
  input  wire logic per_oe,
  input  wire logic per_out,
  input  wire logic force_in,
  output logic      oe,
  output logic      out,
  output logic      rd,
  output logic      fed
);
  // peripheral owns the pin while its function is on
  assign oe  = force_in ? 1'b0 : (per_use ? per_oe : ddr);
  assign out = per_use ? per_out : dr;
  // latch for outputs, live level for inputs
  assign rd  = ddr ? dr : pin_in;
  assign fed = ddr ? dr : pin_in;
endmodule // port_pin_mux

// ---- rtl/shared_gpio_ports.sv ----
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module shared_gpio_ports (
  input  wire logic                                CLK,
  input  wire logic                                ARST_N,
  input  wire logic [shared_port_pkg::ADDR_W-1:0]  ADDR,
  input  wire logic [shared_port_pkg::DATA_W-1:0]  WDATA,
  input  wire logic                                WR,
  input  wire logic                                RD,
  output logic      [shared_port_pkg::DATA_W-1:0]  RDATA,
  input  wire logic                                HW_STANDBY,
  input  wire logic                                SW_STANDBY,
  input  wire logic [shared_port_pkg::TMR_W-1:0]   TMR_PORT_IN,
  output logic      [shared_port_pkg::TMR_W-1:0]   TMR_PORT_OUT,
  output logic      [shared_port_pkg::TMR_W-1:0]   TMR_PORT_OE,
  input  wire logic [1:0]                          TMR_OUT_EN,
  input  wire logic [1:0]                          TMR_OUT_VAL,
  input  wire logic [1:0]                          PWM_OUT_EN,
  input  wire logic [1:0]                          PWM_OUT_VAL,
  output logic      [1:0]                          TMR_CLK_IN,
  output logic      [1:0]                          TMR_RST_IN,
  input  wire logic [shared_port_pkg::SER_W-1:0]   SER_PORT_IN,
  output logic      [shared_port_pkg::SER_W-1:0]   SER_PORT_OUT,
  output logic      [shared_port_pkg::SER_W-1:0]   SER_PORT_OE,
  input  wire logic                                SCI_TX_EN,
  input  wire logic                                SCI_TX_VAL,
  input  wire logic                                SCI_RX_EN,
  input  wire logic                                SCI_CLK_EN,
  input  wire logic                                SCI_CLK_DIR,
  input  wire logic                                SCI_CLK_VAL,
  output logic                                     SCI_RX_IN,
  output logic                                     SCI_CLK_IN,
  input  wire logic [shared_port_pkg::FRT_W-1:0]   FRT_PORT_IN,
  output logic      [shared_port_pkg::FRT_W-1:0]   FRT_PORT_OUT,
  output logic      [shared_port_pkg::FRT_W-1:0]   FRT_PORT_OE,
  input  wire logic                                FRT_CMA_EN,
  input  wire logic                                FRT_CMA_VAL,
  input  wire logic                                FRT_CMB_EN,
  input  wire logic                                FRT_CMB_VAL,
  input  wire logic [1:0]                          IRQ_EN,
  output logic                                     FRT_CLK_IN,
  output logic      [shared_port_pkg::FRT_CAP_N-1:0] FRT_CAP_IN,
  output logic      [1:0]                          EXT_IRQ_IN
);
  import shared_port_pkg::*;

  logic [DATA_W-1:0] tmr_ddr;
  logic [DATA_W-1:0] tmr_dr;
  logic [DATA_W-1:0] ser_ddr;
  logic [DATA_W-1:0] ser_dr;
  logic [DATA_W-1:0] frt_ddr;
  logic [DATA_W-1:0] frt_dr;
  logic [TMR_W-1:0]  tmr_use, tmr_pout, tmr_oe, tmr_out, tmr_rd, tmr_fed;
  logic [SER_W-1:0]  ser_use, ser_poe, ser_pout, ser_oe, ser_out, ser_rd;
  logic [FRT_W-1:0]  frt_use, frt_pout, frt_oe, frt_out, frt_rd, frt_fed;
  logic [DATA_W-1:0] nxt_rdata;
  logic [DATA_W-1:0] rdata_ff;
  logic [TMR_W-1:0]  tmr_oe_ff, tmr_out_ff;
  logic [SER_W-1:0]  ser_oe_ff, ser_out_ff;
  logic [FRT_W-1:0]  frt_oe_ff, frt_out_ff;
  logic [1:0]        tmr_clk_ff, tmr_rst_ff, irq_ff;
  logic              sci_rx_ff, sci_clk_ff, frt_clk_ff;
  logic [FRT_CAP_N-1:0] frt_cap_ff;
  logic [1:0]        nxt_irq;

  // peripheral pin ownership lives only outside both standby modes
  wire per_ok     = !SW_STANDBY && !HW_STANDBY;
  wire wr_tmr_ddr = WR && (ADDR == A_TMR_DDR);
  wire wr_tmr_dr  = WR && (ADDR == A_TMR_DR);
  wire wr_ser_ddr = WR && (ADDR == A_SER_DDR);
  wire wr_ser_dr  = WR && (ADDR == A_SER_DR);
  wire wr_frt_ddr = WR && (ADDR == A_FRT_DDR);
  wire wr_frt_dr  = WR && (ADDR == A_FRT_DR);

  // registers; hardware standby clears them like reset
  port_latch_reg #(.W(DATA_W), .RST(RST_TMR), .WMASK(MASK_ALL)) u_tmr_ddr (
    .clk(CLK), .arst_n(ARST_N), .hw_clear(HW_STANDBY),
    .wr_en(wr_tmr_ddr), .wdata(WDATA), .q(tmr_ddr));
  port_latch_reg #(.W(DATA_W), .RST(RST_TMR), .WMASK(MASK_ALL)) u_tmr_dr (
    .clk(CLK), .arst_n(ARST_N), .hw_clear(HW_STANDBY),
    .wr_en(wr_tmr_dr), .wdata(WDATA), .q(tmr_dr));
  port_latch_reg #(.W(DATA_W), .RST(RST_SER), .WMASK(MASK_SER)) u_ser_ddr (
    .clk(CLK), .arst_n(ARST_N), .hw_clear(HW_STANDBY),
    .wr_en(wr_ser_ddr), .wdata(WDATA), .q(ser_ddr));
  port_latch_reg #(.W(DATA_W), .RST(RST_SER), .WMASK(MASK_SER)) u_ser_dr (
    .clk(CLK), .arst_n(ARST_N), .hw_clear(HW_STANDBY),
    .wr_en(wr_ser_dr), .wdata(WDATA), .q(ser_dr));
  port_latch_reg #(.W(DATA_W), .RST(RST_FRT), .WMASK(MASK_ALL)) u_frt_ddr (
    .clk(CLK), .arst_n(ARST_N), .hw_clear(HW_STANDBY),
    .wr_en(wr_frt_ddr), .wdata(WDATA), .q(frt_ddr));
  port_latch_reg #(.W(DATA_W), .RST(RST_FRT), .WMASK(MASK_ALL)) u_frt_dr (
    .clk(CLK), .arst_n(ARST_N), .hw_clear(HW_STANDBY),
    .wr_en(wr_frt_dr), .wdata(WDATA), .q(frt_dr));

  // peripheral ownership per pin
  always_comb begin
    tmr_use = '0;
    tmr_pout = '0;
    tmr_use[TMR_OUT0_BIT]  = TMR_OUT_EN[0] && per_ok;
    tmr_use[TMR_OUT1_BIT]  = TMR_OUT_EN[1] && per_ok;
    tmr_use[PWM0_BIT]      = PWM_OUT_EN[0] && per_ok;
    tmr_use[PWM1_BIT]      = PWM_OUT_EN[1] && per_ok;
    tmr_pout[TMR_OUT0_BIT] = TMR_OUT_VAL[0];
    tmr_pout[TMR_OUT1_BIT] = TMR_OUT_VAL[1];
    tmr_pout[PWM0_BIT]     = PWM_OUT_VAL[0];
    tmr_pout[PWM1_BIT]     = PWM_OUT_VAL[1];
  end

  always_comb begin
    ser_use = '0;
    ser_poe = '0;
    ser_pout = '0;
    ser_use[SER_TX_BIT]   = SCI_TX_EN && per_ok;
    ser_poe[SER_TX_BIT]   = 1'b1;
    ser_pout[SER_TX_BIT]  = SCI_TX_VAL;
    ser_use[SER_RX_BIT]   = SCI_RX_EN && per_ok;
    ser_use[SER_CLK_BIT]  = SCI_CLK_EN && per_ok;
    ser_poe[SER_CLK_BIT]  = SCI_CLK_DIR;
    ser_pout[SER_CLK_BIT] = SCI_CLK_VAL;
  end

  always_comb begin
    frt_use = '0;
    frt_pout = '0;
    frt_use[FRT_CMA_BIT]  = FRT_CMA_EN && per_ok;
    frt_use[FRT_CMB_BIT]  = FRT_CMB_EN && per_ok;
    frt_pout[FRT_CMA_BIT] = FRT_CMA_VAL;
    frt_pout[FRT_CMB_BIT] = FRT_CMB_VAL;
  end

  // one pin cell per bit
  genvar gi;
  generate
    for (gi = 0; gi < TMR_W; gi++) begin : g_tmr
      port_pin_mux u_pin (
        .ddr(tmr_ddr[gi]), .dr(tmr_dr[gi]), .pin_in(TMR_PORT_IN[gi]),
        .per_use(tmr_use[gi]), .per_oe(1'b1), .per_out(tmr_pout[gi]),
        .force_in(HW_STANDBY), .oe(tmr_oe[gi]), .out(tmr_out[gi]),
        .rd(tmr_rd[gi]), .fed(tmr_fed[gi]));
    end
    for (gi = 0; gi < SER_W; gi++) begin : g_ser
      port_pin_mux u_pin (
        .ddr(ser_ddr[gi]), .dr(ser_dr[gi]), .pin_in(SER_PORT_IN[gi]),
        .per_use(ser_use[gi]), .per_oe(ser_poe[gi]), .per_out(ser_pout[gi]),
        .force_in(HW_STANDBY), .oe(ser_oe[gi]), .out(ser_out[gi]),
        .rd(ser_rd[gi]), .fed());
    end
    for (gi = 0; gi < FRT_W; gi++) begin : g_frt
      port_pin_mux u_pin (
        .ddr(frt_ddr[gi]), .dr(frt_dr[gi]), .pin_in(FRT_PORT_IN[gi]),
        .per_use(frt_use[gi]), .per_oe(1'b1), .per_out(frt_pout[gi]),
        .force_in(HW_STANDBY), .oe(frt_oe[gi]), .out(frt_out[gi]),
        .rd(frt_rd[gi]), .fed(frt_fed[gi]));
    end
  endgenerate

  // read mux; direction registers read back as all ones
  wire [DATA_W-1:0] ser_rd_word = (RST_SER & ~MASK_SER) | {{(DATA_W-SER_W){1'b0}}, ser_rd};
  assign nxt_rdata = (ADDR == A_TMR_DR)  ? tmr_rd :
                     (ADDR == A_SER_DR)  ? ser_rd_word :
                     (ADDR == A_FRT_DR)  ? frt_rd :
                     (ADDR == A_TMR_DDR) ? RD_WO :
                     (ADDR == A_SER_DDR) ? RD_WO :
                     (ADDR == A_FRT_DDR) ? RD_WO : RD_NONE;

  // interrupt lines idle high when their enable is off
  assign nxt_irq[0] = IRQ_EN[0] ? frt_fed[FRT_EXT_INTERRUPT_SIX_BIT] : 1'b1;
  assign nxt_irq[1] = IRQ_EN[1] ? frt_fed[FRT_EXT_INTERRUPT_SEVEN_BIT] : 1'b1;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_ff <= RD_NONE;
    end else begin
      rdata_ff <= RD ? nxt_rdata : RD_NONE;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tmr_oe_ff  <= '0;
      tmr_out_ff <= '0;
      ser_oe_ff  <= '0;
      ser_out_ff <= '0;
      frt_oe_ff  <= '0;
      frt_out_ff <= '0;
    end else begin
      tmr_oe_ff  <= tmr_oe;
      tmr_out_ff <= tmr_out;
      ser_oe_ff  <= ser_oe;
      ser_out_ff <= ser_out;
      frt_oe_ff  <= frt_oe;
      frt_out_ff <= frt_out;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tmr_clk_ff <= '0;
      tmr_rst_ff <= '0;
      sci_rx_ff  <= 1'b1;
      sci_clk_ff <= 1'b0;
      frt_clk_ff <= 1'b0;
      frt_cap_ff <= '0;
      irq_ff     <= 2'h3;
    end else begin
      tmr_clk_ff <= {tmr_fed[TMR_CLK1_BIT], tmr_fed[TMR_CLK0_BIT]};
      tmr_rst_ff <= {tmr_fed[TMR_RST1_BIT], tmr_fed[TMR_RST0_BIT]};
      sci_rx_ff  <= SER_PORT_IN[SER_RX_BIT];
      sci_clk_ff <= SER_PORT_IN[SER_CLK_BIT];
      frt_clk_ff <= frt_fed[FRT_CLK_BIT];
      frt_cap_ff <= frt_fed[FRT_CAP0_BIT +: FRT_CAP_N];
      irq_ff     <= nxt_irq;
    end
  end

  assign RDATA        = rdata_ff;
  assign TMR_PORT_OE  = tmr_oe_ff;
  assign TMR_PORT_OUT = tmr_out_ff;
  assign SER_PORT_OE  = ser_oe_ff;
  assign SER_PORT_OUT = ser_out_ff;
  assign FRT_PORT_OE  = frt_oe_ff;
  assign FRT_PORT_OUT = frt_out_ff;
  assign TMR_CLK_IN   = tmr_clk_ff;
  assign TMR_RST_IN   = tmr_rst_ff;
  assign SCI_RX_IN    = sci_rx_ff;
  assign SCI_CLK_IN   = sci_clk_ff;
  assign FRT_CLK_IN   = frt_clk_ff;
  assign FRT_CAP_IN   = frt_cap_ff;
  assign EXT_IRQ_IN   = irq_ff;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  AST_RD_LATCH: assert property (
    (RD && ADDR == A_FRT_DR && frt_ddr == 8'hFF) |=> (RDATA == $past(frt_dr)))
    else $error("frt data read ignores latch on output pins");

  AST_RD_PIN: assert property (
    (RD && ADDR == A_TMR_DR && tmr_ddr == 8'h00) |=> (RDATA == $past(TMR_PORT_IN)))
    else $error("timer data read ignores pin level on input pins");

  AST_RD_ONLY_ONE: assert property (
    !RD |=> (RDATA == RD_NONE))
    else $error("read data present without a read");

  AST_FRT_DIR: assert property (
    (per_ok && !FRT_CMA_EN && !FRT_CMB_EN) |=> (FRT_PORT_OE == $past(frt_ddr)))
    else $error("frt pin direction differs from direction bits");

  AST_TMR_FED: assert property (
    tmr_ddr[TMR_CLK0_BIT] |=> (TMR_CLK_IN[0] == $past(tmr_dr[TMR_CLK0_BIT])))
    else $error("timer clock input not taken from latch");

  AST_TMR_OVR: assert property (
    (per_ok && TMR_OUT_EN[0]) |=> (TMR_PORT_OE[TMR_OUT0_BIT]
      && TMR_PORT_OUT[TMR_OUT0_BIT] == $past(TMR_OUT_VAL[0])))
    else $error("timer output pin not driven by timer");

  AST_HW_CLEAR: assert property (
    HW_STANDBY |=> (tmr_ddr == RST_TMR && tmr_dr == RST_TMR && TMR_PORT_OE == '0
      && FRT_PORT_OE == '0 && SER_PORT_OE == '0))
    else $error("hardware standby left a pin driven or a register set");

  AST_SW_KEEP: assert property (
    (SW_STANDBY && !HW_STANDBY && !WR) |=> ($stable(tmr_ddr) && $stable(tmr_dr)
      ##0 TMR_PORT_OE == $past(tmr_ddr) && TMR_PORT_OUT == $past(tmr_dr)))
    else $error("software standby changed timer port state");

  AST_SER_TX: assert property (
    (per_ok && SCI_TX_EN) |=> (SER_PORT_OE[SER_TX_BIT]
      && SER_PORT_OUT[SER_TX_BIT] == $past(SCI_TX_VAL)))
    else $error("transmit pin not steered by serial logic");

  AST_SER_FIXED: assert property (
    ((ser_ddr & ~MASK_SER) == (RST_SER & ~MASK_SER))
      && ((ser_dr & ~MASK_SER) == (RST_SER & ~MASK_SER)))
    else $error("serial port upper bits not fixed at one");

  AST_FRT_CAP: assert property (
    (frt_ddr[FRT_CAP0_BIT] && !HW_STANDBY)
      |=> (FRT_CAP_IN[0] == $past(frt_dr[FRT_CAP0_BIT])))
    else $error("capture input not taken from latch");

  AST_CMB_OVR: assert property (
    (per_ok && FRT_CMB_EN) |=> (FRT_PORT_OE[FRT_CMB_BIT]
      && FRT_PORT_OUT[FRT_CMB_BIT] == $past(FRT_CMB_VAL)))
    else $error("compare B pin not driven by timer");

  AST_CMA_OVR: assert property (
    (per_ok && FRT_CMA_EN) |=> (FRT_PORT_OE[FRT_CMA_BIT]
      && FRT_PORT_OUT[FRT_CMA_BIT] == $past(FRT_CMA_VAL)))
    else $error("compare A pin not driven by timer");

  AST_PWM_OVR: assert property (
    (per_ok && PWM_OUT_EN[1]) |=> (TMR_PORT_OE[PWM1_BIT]
      && TMR_PORT_OUT[PWM1_BIT] == $past(PWM_OUT_VAL[1])))
    else $error("pwm pin not driven by pwm timer");

  AST_SER_DIR: assert property (
    (per_ok && !SCI_TX_EN && !SCI_RX_EN && !SCI_CLK_EN)
      |=> (SER_PORT_OE == $past(ser_ddr[SER_W-1:0])))
    else $error("serial pin direction differs from direction bits");

  AST_SER_RX: assert property (
    (per_ok && SCI_RX_EN) |=> !SER_PORT_OE[SER_RX_BIT])
    else $error("receive pin driven while serial owns it");

  AST_SER_CLK: assert property (
    (per_ok && SCI_CLK_EN) |=> (SER_PORT_OE[SER_CLK_BIT] == $past(SCI_CLK_DIR)))
    else $error("serial clock pin direction not set by serial logic");

  AST_IRQ_LATCH: assert property (
    (IRQ_EN[1] && frt_ddr[FRT_EXT_INTERRUPT_SEVEN_BIT])
      |=> (EXT_IRQ_IN[1] == $past(frt_dr[FRT_EXT_INTERRUPT_SEVEN_BIT])))
    else $error("interrupt line not taken from latch on output pin");

  AST_SW_FRT: assert property (
    (SW_STANDBY && !HW_STANDBY) |=> (FRT_PORT_OE == $past(frt_ddr)
      && FRT_PORT_OUT == $past(frt_dr)))
    else $error("software standby pins do not follow frt port bits");

  AST_SW_SER: assert property (
    (SW_STANDBY && !HW_STANDBY) |=> (SER_PORT_OE == $past(ser_ddr[SER_W-1:0])
      && SER_PORT_OUT == $past(ser_dr[SER_W-1:0])))
    else $error("software standby pins do not follow serial port bits");

  COV_WRITE_READ: cover property (
    (WR && ADDR == A_FRT_DR) ##1 (RD && ADDR == A_FRT_DR));
  COV_SW_STANDBY: cover property (
    (per_ok && PWM_OUT_EN[0]) ##1 SW_STANDBY);
  COV_SER_CLK_OUT: cover property (
    per_ok && SCI_CLK_EN && SCI_CLK_DIR);
  COV_HW_STANDBY: cover property (
    $rose(HW_STANDBY));

endmodule // shared_gpio_ports

// ---- test/pin_board_model.sv ----
`timescale 1ns/1ps
module pin_board_model (
  input  wire logic [7:0] tmr_oe,
  input  wire logic [7:0] tmr_out,
  input  wire logic [7:0] tmr_ext,
  output logic      [7:0] tmr_pin,
  input  wire logic [2:0] ser_oe,
  input  wire logic [2:0] ser_out,
  input  wire logic [2:0] ser_ext,
  output logic      [2:0] ser_pin,
  input  wire logic [7:0] frt_oe,
  input  wire logic [7:0] frt_out,
  input  wire logic [7:0] frt_ext,
  output logic      [7:0] frt_pin
);
  // driven pins follow the device, released pins show the board level
  assign tmr_pin = (tmr_oe & tmr_out) | (~tmr_oe & tmr_ext);
  assign ser_pin = (ser_oe & ser_out) | (~ser_oe & ser_ext);
  assign frt_pin = (frt_oe & frt_out) | (~frt_oe & frt_ext);
endmodule // pin_board_model

// ---- test/tb.sv ----
`timescale 1ns/1ps
module tb;
  import shared_port_pkg::*;
  logic        clk, arst_n, wr, rd, hw_stby, sw_stby;
  logic [15:0] addr;
  logic [7:0]  wdata, rdata;
  logic [7:0]  t_ext, t_pin, t_out, t_oe, f_ext, f_pin, f_out, f_oe;
  logic [2:0]  s_ext, s_pin, s_out, s_oe;
  logic [1:0]  tmr_en, tmr_val, pwm_en, pwm_val, tclk, trst, irq_en, irq_in;
  logic        tx_en, tx_val, rx_en, ck_en, ck_dir, ck_val, sci_rx, sci_ck;
  logic        cma_en, cma_val, cmb_en, cmb_val, fclk;
  logic [3:0]  fcap;
  int          mismatches, checks;

  shared_gpio_ports DUT (.CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .HW_STANDBY(hw_stby), .SW_STANDBY(sw_stby),
    .TMR_PORT_IN(t_pin), .TMR_PORT_OUT(t_out), .TMR_PORT_OE(t_oe), .TMR_OUT_EN(tmr_en),
    .TMR_OUT_VAL(tmr_val), .PWM_OUT_EN(pwm_en), .PWM_OUT_VAL(pwm_val), .TMR_CLK_IN(tclk),
    .TMR_RST_IN(trst), .SER_PORT_IN(s_pin), .SER_PORT_OUT(s_out), .SER_PORT_OE(s_oe),
    .SCI_TX_EN(tx_en), .SCI_TX_VAL(tx_val), .SCI_RX_EN(rx_en), .SCI_CLK_EN(ck_en),
    .SCI_CLK_DIR(ck_dir), .SCI_CLK_VAL(ck_val), .SCI_RX_IN(sci_rx), .SCI_CLK_IN(sci_ck),
    .FRT_PORT_IN(f_pin), .FRT_PORT_OUT(f_out), .FRT_PORT_OE(f_oe), .FRT_CMA_EN(cma_en),
    .FRT_CMA_VAL(cma_val), .FRT_CMB_EN(cmb_en), .FRT_CMB_VAL(cmb_val), .IRQ_EN(irq_en),
    .FRT_CLK_IN(fclk), .FRT_CAP_IN(fcap), .EXT_IRQ_IN(irq_in));

  pin_board_model board (.tmr_oe(t_oe), .tmr_out(t_out), .tmr_ext(t_ext), .tmr_pin(t_pin),
    .ser_oe(s_oe), .ser_out(s_out), .ser_ext(s_ext), .ser_pin(s_pin),
    .frt_oe(f_oe), .frt_out(f_out), .frt_ext(f_ext), .frt_pin(f_pin));

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic periph(input logic on);
    tmr_en <= {2{on}};
    pwm_en <= {2{on}};
    tx_en <= on;
    rx_en <= on;
    ck_en <= on;
    cma_en <= on;
    cmb_en <= on;
  endtask

  task automatic t_reset_vals();
    t_ext <= 8'hA5;
    s_ext <= 3'h6;
    f_ext <= 8'h3C;
    cyc(2);
    chk(t_oe, 8'h00);
    chk({5'h00, s_oe}, 8'h00);
    chk(f_oe, 8'h00);
    rd_chk(A_TMR_DDR, RD_WO);
    rd_chk(A_TMR_DR, 8'hA5);
    rd_chk(A_SER_DR, 8'hFE);
    rd_chk(A_FRT_DR, 8'h3C);
    rd_chk(16'hFFB6, RD_NONE);
  endtask

  task automatic t_read_mix();
    wr_reg(A_TMR_DDR, 8'h0F);
    wr_reg(A_TMR_DR, 8'h55);
    wr_reg(A_SER_DDR, 8'hFD);
    wr_reg(A_SER_DR, 8'h03);
    wr_reg(A_FRT_DDR, 8'hF0);
    wr_reg(A_FRT_DR, 8'h9A);
    t_ext <= 8'hAA;
    s_ext <= 3'h2;
    cyc(2);
    chk(t_oe, 8'h0F);
    chk(t_out & t_oe, 8'h05);
    chk({5'h00, s_oe}, 8'h05);
    chk(f_oe, 8'hF0);
    chk({6'h00, tclk}, 8'h01);
    chk({6'h00, trst}, 8'h03);
    chk({3'h0, fcap, fclk}, 8'h0E);
    rd_chk(A_TMR_DR, 8'hA5);
    rd_chk(A_SER_DR, 8'hFB);
    rd_chk(A_FRT_DR, 8'h9C);
  endtask

  task automatic t_periph();
    wr_reg(A_SER_DDR, 8'h02);
    periph(1'b1);
    tmr_val <= 2'b01;
    pwm_val <= 2'b10;
    tx_val <= 1'b0;
    ck_dir <= 1'b1;
    ck_val <= 1'b1;
    cma_val <= 1'b0;
    cmb_val <= 1'b1;
    s_ext <= 3'h1;
    f_ext <= 8'h3E;
    cyc(2);
    chk(t_oe, 8'hDF);
    chk(t_out & t_oe, 8'h87);
    chk({5'h00, s_oe}, 8'h05);
    chk({5'h00, s_out & s_oe}, 8'h04);
    chk({6'h00, sci_ck, sci_rx}, 8'h02);
    chk(f_oe, 8'hF2);
    chk(f_out & f_oe, 8'hD0);
    rd_chk(A_TMR_DR, 8'hA5);
    rd_chk(A_SER_DR, 8'hFE);
    rd_chk(A_FRT_DR, 8'h9C);
    ck_dir <= 1'b0;
    cyc(2);
    chk({5'h00, s_oe}, 8'h01);
    chk({6'h00, sci_ck, sci_rx}, 8'h00);
  endtask

  task automatic t_irq();
    periph(1'b0);
    irq_en <= 2'b11;
    cyc(2);
    chk({6'h00, irq_in}, 8'h02);
    wr_reg(A_FRT_DDR, 8'h30);
    cyc(2);
    chk({6'h00, irq_in}, 8'h00);
    irq_en <= 2'b00;
    cyc(2);
    chk({6'h00, irq_in}, 8'h03);
  endtask

  task automatic t_sw_stby();
    periph(1'b1);
    sw_stby <= 1'b1;
    cyc(2);
    chk(t_oe, 8'h0F);
    chk(t_out & t_oe, 8'h05);
    chk({5'h00, s_oe}, 8'h02);
    chk({5'h00, s_out & s_oe}, 8'h02);
    chk(f_oe, 8'h30);
    chk(f_out & f_oe, 8'h10);
    rd_chk(A_TMR_DR, 8'hA5);
    sw_stby <= 1'b0;
    periph(1'b0);
  endtask

  task automatic t_hw_stby();
    hw_stby <= 1'b1;
    cyc(2);
    chk(t_oe, 8'h00);
    chk({5'h00, s_oe}, 8'h00);
    chk(f_oe, 8'h00);
    wr_reg(A_FRT_DR, 8'hFF);
    hw_stby <= 1'b0;
    cyc(1);
    wr_reg(A_TMR_DDR, 8'hFF);
    wr_reg(A_SER_DDR, 8'hFF);
    wr_reg(A_FRT_DDR, 8'hFF);
    rd_chk(A_TMR_DR, 8'h00);
    rd_chk(A_SER_DR, 8'hF8);
    rd_chk(A_FRT_DR, 8'h00);
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (2000) @(posedge clk);
    mismatches++;
    summarize();
  end

  initial begin
    {arst_n, wr, rd, hw_stby, sw_stby, addr, wdata} = '0;
    {tmr_en, tmr_val, pwm_en, pwm_val, irq_en} = '0;
    {tx_en, tx_val, rx_en, ck_en, ck_dir, ck_val, cma_en, cma_val, cmb_en, cmb_val} = '0;
    {t_ext, s_ext, f_ext} = '0;
    mismatches = 0;
    checks = 0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    #1;
    t_reset_vals();
    t_read_mix();
    t_periph();
    t_irq();
    t_sw_stby();
    t_hw_stby();
    summarize();
  end
endmodule // tb
